// file: rtl/i2cs_pkg.sv
// Shared constants for both ends of the two-channel switch control link
// Assumes a 100 MHz system clock on both ends
package i2cs_pkg;
   // System clock
   localparam int CLK_PERIOD_NS = 10;
   // Interrupt timing
   localparam int IRQ_MIN_LOW_PULSE_NS = 1000;
   localparam int IRQ_MIN_HIGH_PULSE_NS = 500;
   localparam int IRQ_ASSERT_LATENCY_NS = 4000;
   localparam int IRQ_RELEASE_LATENCY_NS = 2000;
   localparam logic [7:0] IRQ_LOW_CYC =
      8'((IRQ_MIN_LOW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] IRQ_HIGH_CYC =
      8'((IRQ_MIN_HIGH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Reset timing
   localparam int RESET_MIN_LOW_WIDTH_NS = 4;
   localparam int RESET_SDA_CLEAR_NS = 500;
   localparam int RESET_RECOVERY_TIME_NS = 0;
   // Serial clock made by the host, 400 kHz, quarter period rounded up
   localparam int SCL_PERIOD_NS = 2500;
   localparam logic [7:0] QUARTER_CYC =
      8'((SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Slave address upper five bits, low two from the select pins
   localparam logic [4:0] ADDR_BASE = 5'h10;
   // Control register layout
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CTRL_EN0_BIT = 0;
   localparam int CTRL_EN1_BIT = 1;
   localparam int CTRL_IRQ0_BIT = 4;
   localparam int CTRL_IRQ1_BIT = 5;
   // Host register map
   localparam logic [3:0] CMD_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam int CMD_RD_BIT = 8;
   localparam int CMD_SEL_LSB = 9;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam int STAT_RDATA_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/i2cs_if.sv
// Two-wire link between the host end and the device end
// Assumes pull-ups: a line is low only while some end enables a low drive
`timescale 1ns/1ps
interface i2cs_if;
   // Drives of each end
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   // Resolved open-drain line levels
   logic scl;
   logic sda;
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
      output host_sda_o, output host_sda_oe);
   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// file: rtl/i2cs_host.sv
// Host end: AXI4-Lite command registers driving a two-wire bus master
// Assumes one transfer at a time; no clock stretching by the device
`timescale 1ns/1ps
module i2cs_host
   import i2cs_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // AXI4-Lite slave
   input wire logic [3:0] axi_awaddr_in,
   input wire logic axi_awvalid_in,
   output logic axi_awready_out,
   input wire logic [31:0] axi_wdata_in,
   input wire logic [3:0] axi_wstrb_in,
   input wire logic axi_wvalid_in,
   output logic axi_wready_out,
   output logic [1:0] axi_bresp_out,
   output logic axi_bvalid_out,
   input wire logic axi_bready_in,
   input wire logic [3:0] axi_araddr_in,
   input wire logic axi_arvalid_in,
   output logic axi_arready_out,
   output logic [31:0] axi_rdata_out,
   output logic [1:0] axi_rresp_out,
   output logic axi_rvalid_out,
   input wire logic axi_rready_in,
   // Link
   i2cs_if.host bus
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b10, H_STOP = 2'b11
   } i2cs_hstate_t;
   i2cs_hstate_t state;
   logic aw_got, w_got, launch, cmd_rd, busy, nack, byte1, sda_s1, sda_s;
   logic [3:0] waddr;
   logic [31:0] wdata;
   logic [7:0] cmd_data, rdata, qcnt;
   logic [1:0] cmd_sel, qph;
   logic [8:0] tx, rx;
   logic [3:0] bitn;

   // Open-drain lines only ever pull low
   assign bus.host_scl_o = 1'b0;
   assign bus.host_sda_o = 1'b0;

   // Write channels taken in either order, answer after both
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         axi_awready_out <= 1'b0;
         axi_wready_out <= 1'b0;
         axi_bvalid_out <= 1'b0;
         axi_bresp_out <= RESP_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         waddr <= 4'h0;
         wdata <= 32'h0;
         launch <= 1'b0;
         cmd_data <= 8'h00;
         cmd_rd <= 1'b0;
         cmd_sel <= 2'h0;
      end else begin
         launch <= 1'b0;
         axi_awready_out <= ~axi_awready_out & axi_awvalid_in & ~aw_got & ~axi_bvalid_out;
         axi_wready_out <= ~axi_wready_out & axi_wvalid_in & ~w_got & ~axi_bvalid_out;
         if (axi_awready_out & axi_awvalid_in) begin
            aw_got <= 1'b1;
            waddr <= axi_awaddr_in;
         end
         if (axi_wready_out & axi_wvalid_in) begin
            w_got <= 1'b1;
            wdata <= axi_wdata_in;
         end
         if (aw_got & w_got & ~axi_bvalid_out) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            axi_bvalid_out <= 1'b1;
            if (waddr == CMD_OFFSET) begin
               axi_bresp_out <= RESP_OKAY;
               // Command ignored while a transfer runs
               if (!busy && !launch && axi_wstrb_in != 4'h0) begin
                  cmd_data <= wdata[7:0];
                  cmd_rd <= wdata[CMD_RD_BIT];
                  cmd_sel <= wdata[CMD_SEL_LSB +: 2];
                  launch <= 1'b1;
               end
            end else if (waddr == STATUS_OFFSET) begin
               axi_bresp_out <= RESP_OKAY;
            end else begin
               axi_bresp_out <= RESP_SLVERR;
            end
         end else if (axi_bvalid_out & axi_bready_in) begin
            axi_bvalid_out <= 1'b0;
         end
      end
   end

   // Read channel with address decode
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         axi_arready_out <= 1'b0;
         axi_rvalid_out <= 1'b0;
         axi_rdata_out <= 32'h0;
         axi_rresp_out <= RESP_OKAY;
      end else begin
         axi_arready_out <= ~axi_arready_out & axi_arvalid_in & ~axi_rvalid_out;
         if (axi_arready_out & axi_arvalid_in) begin
            axi_rvalid_out <= 1'b1;
            axi_rresp_out <= RESP_OKAY;
            axi_rdata_out <= 32'h0;
            if (axi_araddr_in == CMD_OFFSET) begin
               axi_rdata_out <= {21'h0, cmd_sel, cmd_rd, cmd_data};
            end else if (axi_araddr_in == STATUS_OFFSET) begin
               axi_rdata_out <= {16'h0, rdata, 6'h0, nack, busy};
            end else begin
               axi_rresp_out <= RESP_SLVERR;
            end
         end else if (axi_rvalid_out & axi_rready_in) begin
            axi_rvalid_out <= 1'b0;
         end
      end
   end

   // Data line synchroniser
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         sda_s1 <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         sda_s1 <= bus.sda;
         sda_s <= sda_s1;
      end
   end

   // Bus master: start, nine-bit slots, stop, in quarter-period steps
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state <= H_IDLE;
         bus.host_scl_oe <= 1'b0;
         bus.host_sda_oe <= 1'b0;
         qcnt <= 8'h00;
         qph <= 2'h0;
         busy <= 1'b0;
         nack <= 1'b0;
         rdata <= 8'h00;
         tx <= 9'h1FF;
         rx <= 9'h000;
         bitn <= 4'h0;
         byte1 <= 1'b0;
      end else if (state == H_IDLE) begin
         qcnt <= 8'h00;
         qph <= 2'h0;
         if (launch) begin
            state <= H_START;
            busy <= 1'b1;
            nack <= 1'b0;
            tx <= {ADDR_BASE, cmd_sel, cmd_rd, 1'b1};
            bitn <= 4'h0;
            byte1 <= 1'b0;
         end
      end else if (qcnt != QUARTER_CYC - 8'h01) begin
         qcnt <= qcnt + 8'h01;
      end else begin
         qcnt <= 8'h00;
         qph <= qph + 2'h1;
         if (state == H_START) begin
            // Data falls with clock high, then clock falls
            if (qph == 2'h1) bus.host_sda_oe <= 1'b1;
            else if (qph == 2'h2) bus.host_scl_oe <= 1'b1;
            else if (qph == 2'h3) state <= H_BIT;
         end else if (state == H_BIT) begin
            if (qph == 2'h0) begin
               bus.host_sda_oe <= ~tx[8];
            end else if (qph == 2'h1) begin
               bus.host_scl_oe <= 1'b0;
            end else if (qph == 2'h2) begin
               rx <= {rx[7:0], sda_s};
            end else begin
               bus.host_scl_oe <= 1'b1;
               tx <= {tx[7:0], 1'b1};
               bitn <= bitn + 4'h1;
               if (bitn == 4'h8) begin
                  bitn <= 4'h0;
                  if (!byte1) begin
                     byte1 <= 1'b1;
                     // Read: release for data, then NACK the only byte
                     tx <= cmd_rd ? 9'h1FF : {cmd_data, 1'b1};
                     if (rx[0]) begin
                        nack <= 1'b1;
                        state <= H_STOP;
                     end
                  end else begin
                     if (cmd_rd) rdata <= rx[8:1];
                     else nack <= rx[0];
                     state <= H_STOP;
                  end
               end
            end
         end else begin
            // Data rises with clock high
            if (qph == 2'h0) bus.host_sda_oe <= 1'b1;
            else if (qph == 2'h1) bus.host_scl_oe <= 1'b0;
            else if (qph == 2'h2) bus.host_sda_oe <= 1'b0;
            else begin
               state <= H_IDLE;
               busy <= 1'b0;
            end
         end
      end
   end
endmodule // i2cs_host

// file: rtl/i2cs_dev.sv
// Device end: serial slave, control register, channel select, interrupts
// Assumes clk_in far faster than the link; every pin is asynchronous
`timescale 1ns/1ps
module i2cs_dev
   import i2cs_pkg::*;
(
   // Clock and power-on reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Upstream link
   i2cs_if.dev bus,
   // Reset and address select pins
   input wire logic dev_reset_n_in,
   input wire logic addr_select_pin_lo_in,
   input wire logic addr_select_pin_hi_in,
   // Downstream interrupt inputs, channel 1 in bit 1
   input wire logic [1:0] chan_irq_n_in,
   // Channel enables and combined interrupt
   output logic [1:0] chan_en_out,
   output logic irq_n_out
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_ADDR_ACK = 3'b010,
      S_WR = 3'b011,
      S_WR_ACK = 3'b100,
      S_RD = 3'b101,
      S_RD_ACK = 3'b110
   } i2cs_dstate_t;
   i2cs_dstate_t state;

   logic [6:0] sync1, sync2;
   logic scl_d, sda_d, rst, rd_nack;
   logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
   logic [1:0] irq_s, pend_sel;
   logic [3:0] cnt;
   logic [7:0] shreg, rd_byte;
   wire [1:0] irq_flt;

   // Open-drain data line only ever pulls low
   assign bus.dev_sda_o = 1'b0;

   // Two-stage synchronisers for every pin
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         sync1 <= 7'h7F;
         sync2 <= 7'h7F;
      end else begin
         sync1 <= {dev_reset_n_in, addr_select_pin_hi_in, addr_select_pin_lo_in,
            chan_irq_n_in, bus.scl, bus.sda};
         sync2 <= sync1;
      end
   end

   assign sda_s = sync2[0];
   assign scl_s = sync2[1];
   assign irq_s = sync2[3:2];

   // Power-on reset restores all defaults; the reset pin only the slave, selection and channel enables, not the interrupt filters
   assign rst = ~nrst_in | ~sync2[6];

   // Previous line levels for edge detection
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Clock edges and start/stop conditions
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

   // Glitch filters: a level must stand its least width to be taken
   for (genvar i = 0; i < 2; i++) begin : g_irq
      logic flt;
      logic [7:0] fcnt;
      always_ff @(posedge clk_in) begin
         if (!nrst_in) begin
            flt <= 1'b1;
            fcnt <= 8'h00;
         end else if (irq_s[i] == flt) begin
            fcnt <= 8'h00;
         end else if (fcnt == (flt ? IRQ_LOW_CYC : IRQ_HIGH_CYC) - 8'h01) begin
            flt <= irq_s[i];
            fcnt <= 8'h00;
         end else begin
            fcnt <= fcnt + 8'h01;
         end
      end
      assign irq_flt[i] = flt;
   end

   // Combined interrupt, low while either filtered input is low
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         irq_n_out <= 1'b1;
      end else begin
         irq_n_out <= &irq_flt;
      end
   end

   // Byte returned on a read: status sampled now, unused bits zero
   always_comb begin
      rd_byte = CTRL_RESET;
      rd_byte[CTRL_EN0_BIT] = pend_sel[0];
      rd_byte[CTRL_EN1_BIT] = pend_sel[1];
      rd_byte[CTRL_IRQ0_BIT] = ~irq_flt[0];
      rd_byte[CTRL_IRQ1_BIT] = ~irq_flt[1];
   end

   // Serial slave state machine
   always_ff @(posedge clk_in) begin
      if (rst) begin
         state <= S_IDLE;
         cnt <= 4'h0;
         shreg <= 8'h00;
         rd_nack <= 1'b0;
         bus.dev_sda_oe <= 1'b0;
      end else if (start_det) begin
         // Start or repeated start wins over all but reset
         state <= S_ADDR;
         cnt <= 4'h0;
         bus.dev_sda_oe <= 1'b0;
      end else if (stop_det) begin
         state <= S_IDLE;
         bus.dev_sda_oe <= 1'b0;
      end else begin
         case (state)
            S_ADDR: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_s};
                  cnt <= cnt + 4'h1;
               end else if (scl_fall && cnt == 4'h8) begin
                  if (shreg[7:1] == {ADDR_BASE, sync2[5], sync2[4]}) begin
                     bus.dev_sda_oe <= 1'b1;
                     state <= S_ADDR_ACK;
                  end else begin
                     state <= S_IDLE;
                  end
               end
            end
            S_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt <= 4'h0;
                  if (shreg[0]) begin
                     shreg <= rd_byte;
                     bus.dev_sda_oe <= ~rd_byte[7];
                     state <= S_RD;
                  end else begin
                     bus.dev_sda_oe <= 1'b0;
                     state <= S_WR;
                  end
               end
            end
            S_WR: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_s};
                  cnt <= cnt + 4'h1;
               end else if (scl_fall && cnt == 4'h8) begin
                  bus.dev_sda_oe <= 1'b1;
                  state <= S_WR_ACK;
               end
            end
            S_WR_ACK: begin
               if (scl_fall) begin
                  bus.dev_sda_oe <= 1'b0;
                  cnt <= 4'h0;
                  state <= S_WR;
               end
            end
            S_RD: begin
               if (scl_rise) begin
                  cnt <= cnt + 4'h1;
               end else if (scl_fall) begin
                  if (cnt == 4'h8) begin
                     bus.dev_sda_oe <= 1'b0;
                     state <= S_RD_ACK;
                  end else begin
                     bus.dev_sda_oe <= ~shreg[6];
                     shreg <= {shreg[6:0], 1'b0};
                  end
               end
            end
            S_RD_ACK: begin
               if (scl_rise) begin
                  rd_nack <= sda_s;
               end else if (scl_fall) begin
                  if (rd_nack) begin
                     state <= S_IDLE;
                  end else begin
                     shreg <= rd_byte;
                     bus.dev_sda_oe <= ~rd_byte[7];
                     cnt <= 4'h0;
                     state <= S_RD;
                  end
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Written selection, last byte of a transfer kept
   always_ff @(posedge clk_in) begin
      if (rst) begin
         pend_sel <= CTRL_RESET[1:0];
      end else if (state == S_WR && scl_fall && cnt == 4'h8 && !start_det && !stop_det) begin
         pend_sel <= {shreg[CTRL_EN1_BIT], shreg[CTRL_EN0_BIT]};
      end
   end

   // Channel switches follow the selection only at a stop
   always_ff @(posedge clk_in) begin
      if (rst) begin
         chan_en_out <= CTRL_RESET[1:0];
      end else if (stop_det) begin
         chan_en_out <= pend_sel;
      end
   end
endmodule // i2cs_dev

// file: sim/i2cs_properties.sv
// Checker for the two-wire link and the device end's pins
// Assumes the host and device ends share clk_in and nrst_in
`timescale 1ns/1ps
module i2cs_properties (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Link lines and device drive
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe,
   // Device pins
   input wire logic dev_reset_n_in,
   input wire logic [1:0] chan_irq_n_in,
   input wire logic [1:0] chan_en_out,
   input wire logic irq_n_out
);
   logic [8:0] lo_cnt;
   logic [8:0] hi_cnt;
   logic scl_q;
   logic sda_q;
   logic [3:0] since_stop;
   logic [3:0] rst_hist;
   logic rst_near;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // Cycles with some interrupt input low
   always_ff @(posedge clk_in) begin
      if (!nrst_in || &chan_irq_n_in) lo_cnt <= 9'h000;
      else if (lo_cnt != 9'h1FF) lo_cnt <= lo_cnt + 9'h001;
   end
   // Cycles with both interrupt inputs high
   always_ff @(posedge clk_in) begin
      if (!nrst_in || !(&chan_irq_n_in)) hi_cnt <= 9'h000;
      else if (hi_cnt != 9'h1FF) hi_cnt <= hi_cnt + 9'h001;
   end
   // Line history for stop detection
   always_ff @(posedge clk_in) begin
      scl_q <= scl;
      sda_q <= sda;
   end
   // Cycles since a stop or a reset pin low
   always_ff @(posedge clk_in) begin
      if (!nrst_in || !dev_reset_n_in || (scl && scl_q && sda && !sda_q)) since_stop <= 4'h0;
      else if (since_stop != 4'hF) since_stop <= since_stop + 4'h1;
   end
   // Recent reset pin history
   always_ff @(posedge clk_in) begin
      rst_hist <= {rst_hist[2:0], dev_reset_n_in};
   end
   assign rst_near = ~&{rst_hist, dev_reset_n_in};
   property p_irq_assert;
      lo_cnt == 9'h190 |-> !irq_n_out;
   endproperty
   a_irq_assert: assert property (p_irq_assert)
      else $error("interrupt output late");
   property p_irq_release;
      hi_cnt == 9'h0C8 |-> irq_n_out;
   endproperty
   a_irq_release: assert property (p_irq_release)
      else $error("interrupt output not released");
   property p_irq_filter;
      $fell(irq_n_out) |-> lo_cnt >= 9'h064;
   endproperty
   a_irq_filter: assert property (p_irq_filter)
      else $error("short interrupt pulse taken");
   property p_pin_desel;
      (!dev_reset_n_in)[*3] |=> chan_en_out == 2'b00;
   endproperty
   a_pin_desel: assert property (p_pin_desel)
      else $error("reset pin kept a channel");
   property p_pin_sda;
      (!dev_reset_n_in)[*3] |=> !dev_sda_oe;
   endproperty
   a_pin_sda: assert property (p_pin_sda)
      else $error("reset pin kept data line low");
   property p_sel_at_stop;
      $changed(chan_en_out) |-> since_stop < 4'h8;
   endproperty
   a_sel_at_stop: assert property (p_sel_at_stop)
      else $error("channel change away from stop");
   property p_sda_stable;
      $changed(dev_sda_oe) |-> !scl || rst_near;
   endproperty
   a_sda_stable: assert property (p_sda_stable)
      else $error("device data changed with clock high");
   property p_por_state;
      $rose(nrst_in) |-> chan_en_out == 2'b00 && irq_n_out && !dev_sda_oe;
   endproperty
   a_por_state: assert property (p_por_state)
      else $error("state after power-on reset");
endmodule // i2cs_properties

// file: sim/tb_top.sv
// Bench joining host and device ends over the link
// Assumes AXI4-Lite host registers and a device address from strap pins
`timescale 1ns/1ps
module tb_top
   import i2cs_pkg::*;
;
   logic clk_in = 1'b0, nrst_in = 1'b0, dev_rst_n = 1'b1, pin_lo = 1'b0, pin_hi = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid, irq_n;
   logic [1:0] bresp, rresp, chan_en, irq_n_in = 2'b11;
   int n_fail = 0, checks_done = 0, cyc = 0;
   logic [31:0] seed = 32'hAAAB168E;
   // Clock
   always #5 clk_in = ~clk_in;
   i2cs_if bus_if ();
   i2cs_host i2cs_host_inst (.clk_in(clk_in), .nrst_in(nrst_in), .axi_awaddr_in(awaddr),
      .axi_awvalid_in(awvalid), .axi_awready_out(awready), .axi_wdata_in(wdata),
      .axi_wstrb_in(4'hF), .axi_wvalid_in(wvalid), .axi_wready_out(wready),
      .axi_bresp_out(bresp), .axi_bvalid_out(bvalid), .axi_bready_in(bready),
      .axi_araddr_in(araddr), .axi_arvalid_in(arvalid), .axi_arready_out(arready),
      .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
      .axi_rready_in(rready), .bus(bus_if));
   i2cs_dev i2cs_dev_inst (.clk_in(clk_in), .nrst_in(nrst_in), .bus(bus_if),
      .dev_reset_n_in(dev_rst_n), .addr_select_pin_lo_in(pin_lo),
      .addr_select_pin_hi_in(pin_hi), .chan_irq_n_in(irq_n_in), .chan_en_out(chan_en),
      .irq_n_out(irq_n));
   i2cs_properties i2cs_properties_inst (.clk_in(clk_in), .nrst_in(nrst_in),
      .scl(bus_if.scl), .sda(bus_if.sda), .dev_sda_oe(bus_if.dev_sda_oe),
      .dev_reset_n_in(dev_rst_n), .chan_irq_n_in(irq_n_in), .chan_en_out(chan_en),
      .irq_n_out(irq_n));
   // Xorshift source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected read byte
   function automatic logic [7:0] rd_byte(input logic [1:0] irq, input logic [1:0] en);
      return {2'b00, irq, 2'b00, en};
   endfunction
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // AXI write, entered just after an edge
   task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk_in);
   endtask
   // AXI read, entered just after an edge
   task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk_in);
   endtask
   // One link transfer, then poll until idle
   task automatic xfer(input logic rd, input logic [1:0] sel, input logic [7:0] d,
         output logic [31:0] st);
      logic [1:0] r;
      axw(CMD_OFFSET, {21'h0, sel, rd, d}, r);
      chk("cmd_resp", r, RESP_OKAY);
      do axr(STATUS_OFFSET, st, r); while (st[STAT_BUSY_BIT] !== 1'b0);
   endtask
   // Hang guard
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         results();
      end
   end
   // Main sequence
   initial begin
      logic [31:0] v, st, d;
      logic [1:0] r, sel;
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      chk("en_por", chan_en, 2'b00);
      chk("irq_por", irq_n, 1'b1);
      v = rnd();
      sel = v[1:0];
      pin_lo <= v[0];
      pin_hi <= v[1];
      axw(4'h8, rnd(), r);
      chk("aw_unmapped", r, RESP_SLVERR);
      axr(4'hC, d, r);
      chk("ar_unmapped", r, RESP_SLVERR);
      // Status is read-only; a write is answered and has no effect
      axw(STATUS_OFFSET, rnd(), r);
      chk("aw_status", r, RESP_OKAY);
      // Every channel pattern, random unused bits
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         v[1:0] = 2'(i);
         xfer(1'b0, sel, v[7:0], st);
         chk("ack_wr", st[STAT_NACK_BIT], 1'b0);
         repeat (5) @(posedge clk_in);
         chk("en_wr", chan_en, v[1:0]);
      end
      // Command register reads back the last accepted command
      axr(CMD_OFFSET, d, r);
      chk("cmd_back", d, {21'h0, sel, 1'b0, v[7:0]});
      irq_n_in <= 2'b01;
      repeat (150) @(posedge clk_in);
      chk("irq_on", irq_n, 1'b0);
      xfer(1'b1, sel, 8'h00, st);
      chk("rd_byte", st[15:8], rd_byte(2'b10, 2'b11));
      irq_n_in <= 2'b11;
      repeat (100) @(posedge clk_in);
      chk("irq_off", irq_n, 1'b1);
      // Short low pulse, then a short high gap
      irq_n_in <= 2'b10;
      repeat (50) @(posedge clk_in);
      irq_n_in <= 2'b11;
      repeat (150) @(posedge clk_in);
      chk("irq_short", irq_n, 1'b1);
      irq_n_in <= 2'b10;
      repeat (150) @(posedge clk_in);
      irq_n_in <= 2'b11;
      repeat (25) @(posedge clk_in);
      irq_n_in <= 2'b10;
      repeat (100) @(posedge clk_in);
      chk("irq_gap", irq_n, 1'b0);
      // Other address select
      xfer(1'b0, sel ^ 2'b01, 8'h00, st);
      chk("nack_addr", st[STAT_NACK_BIT], 1'b1);
      repeat (5) @(posedge clk_in);
      chk("en_keep", chan_en, 2'b11);
      // Reset pin, then start at once
      dev_rst_n <= 1'b0;
      repeat (3) @(posedge clk_in);
      dev_rst_n <= 1'b1;
      @(posedge clk_in);
      chk("en_pin", chan_en, 2'b00);
      xfer(1'b1, sel, 8'h00, st);
      chk("ack_rd", st[STAT_NACK_BIT], 1'b0);
      chk("rd_after_pin", st[15:8], rd_byte(2'b01, 2'b00));
      // Reset pin while the device drives read data; command while busy ignored
      axw(CMD_OFFSET, {21'h0, sel, 1'b1, 8'h00}, r);
      axw(CMD_OFFSET, {21'h0, sel, 1'b0, 8'h5A}, r);
      chk("busy_wr", r, RESP_OKAY);
      axr(CMD_OFFSET, d, r);
      chk("cmd_keep", d, {21'h0, sel, 1'b1, 8'h00});
      repeat (2600) @(posedge clk_in);
      chk("sda_drv", bus_if.dev_sda_oe, 1'b1);
      dev_rst_n <= 1'b0;
      repeat (3) @(posedge clk_in);
      dev_rst_n <= 1'b1;
      @(posedge clk_in);
      chk("sda_pin", bus_if.dev_sda_oe, 1'b0);
      do axr(STATUS_OFFSET, st, r); while (st[STAT_BUSY_BIT] !== 1'b0);
      xfer(1'b1, sel, 8'h00, st);
      chk("rd_after_cut", st[15:8], rd_byte(2'b01, 2'b00));
      results();
   end
endmodule // tb_top
